// ===== rtl/cbt_pkg.sv
// package of the block-transmit control and identifier mask block
// assumes a 16-bit register port and a bit engine on the same clock

package cbt_pkg;

  // ----------------------------------------------------------------
  // register port layout
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 16;
  localparam logic [7:0]  OFF_CTRL      = 8'h06;
  localparam logic [7:0]  OFF_DELAY     = 8'h08;
  localparam logic [7:0]  OFF_MASK1_LO  = 8'h40;
  localparam logic [7:0]  OFF_MASK1_HI  = 8'h42;
  localparam logic [7:0]  OFF_MASK2_LO  = 8'h44;
  localparam logic [7:0]  OFF_MASK2_HI  = 8'h46;
  localparam logic [3:0]  MASK_PAGE     = 4'h4;
  localparam int          MASK_HALVES   = 8;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          RD_RUN_BIT    = 0;
  localparam int          RD_CLR_BIT    = 1;
  localparam int          WR_STOP_BIT   = 0;
  localparam int          WR_START_BIT  = 8;
  localparam int          WR_CLR_BIT    = 9;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [3:0]  DELAY_RESET   = 4'h0;
  localparam int          DELAY_W       = 4;
  localparam logic [15:0] MASK_HI_VALID = 16'h1FFF;
  localparam int          ID_W          = 29;
  localparam int          ID_LO_W       = 16;

  // ----------------------------------------------------------------
  // engine constants
  // ----------------------------------------------------------------
  localparam logic [3:0]  DELAY_MAX     = 4'h8;
  localparam logic [3:0]  DELAY_EXP_ADD = 4'h4;
  localparam int          GAP_W         = 13;
  localparam logic [2:0]  BUF_FIRST     = 3'h0;
  localparam logic [2:0]  CLEAR_CYCLES  = 3'h4;

  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } cbt_bus_req_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] buf_idx;
  } cbt_tx_req_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_BUSY,
    ST_GAP,
    ST_CLEAR
  } cbt_state_t;

endpackage

// ===== rtl/cbt_id_match.sv
// masked identifier comparator for one receive buffer
// assumes the caller registers the result; purely combinational here

`timescale 1ns/1ns

module cbt_id_match (
  input  wire logic [cbt_pkg::ID_W-1:0] i_rx_id,
  input  wire logic [cbt_pkg::ID_W-1:0] i_buf_id,
  input  wire logic [cbt_pkg::ID_W-1:0] i_mask,
  output logic                          o_match
);
  import cbt_pkg::*;

  logic [ID_W-1:0] bit_ok;

  // ----------------------------------------------------------------
  // per-bit compare, a set mask bit drops that bit from the test
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ID_W; g++) begin : g_bit
      assign bit_ok[g] = i_mask[g] | ~(i_rx_id[g] ^ i_buf_id[g]);
    end
  endgenerate

  // all bits must pass for acceptance
  assign o_match = &bit_ok;

endmodule

// ===== rtl/cbt_top.sv
// block-transmit engine, frame delay and identifier mask registers
// assumes bit engine handshakes and data bit tick on I_MCLK
//
// Functional notes
// - writing clear bit starts engine clear
// - after clear, start resumes at buffer zero
// - start/stop bit pair updates run flag
// - 8-bit delay register, low nibble used
// - delay register resets to zero
// - code n of 1..8 gives two^(n+4) bit times gap, code 0 none
// - ordinary buffer requests may postpone frames
// - four mask pairs widen identifier matching
// - mask pair one at 040h and 042h
// - mask pair two at 044h and 046h
// - masks are 16-bit words, undefined at reset
// - clear status reads one until clear ends

`timescale 1ns/1ns

module cbt_top (
  input  wire logic                          I_MCLK,
  input  wire logic                          I_RESET_N,
  input  wire cbt_pkg::cbt_bus_req_t         I_BUS,
  input  wire logic                          I_DBT_TICK,
  input  wire logic                          I_ORD_PEND,
  input  wire logic                          I_TX_ACK,
  input  wire logic                          I_TX_DONE,
  input  wire logic [cbt_pkg::ID_W-1:0]      I_RX_ID,
  input  wire logic [cbt_pkg::ID_W-1:0]      I_BUF_ID,
  input  wire logic [2:0]                    I_MASK_SEL,
  output logic [cbt_pkg::DATA_W-1:0]         O_RDATA,
  output cbt_pkg::cbt_tx_req_t               O_TX_REQ,
  output logic                               O_RUN,
  output logic                               O_CLEARING,
  output logic                               O_ID_MATCH
);
  import cbt_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cbt_state_t         state_r;
  cbt_state_t         state_nxt;
  logic               run_r;
  logic               run_nxt;
  logic [DELAY_W-1:0] delay_r;
  logic [DELAY_W-1:0] delay_nxt;
  logic [2:0]         idx_r;
  logic [2:0]         idx_nxt;
  logic [GAP_W-1:0]   gap_r;
  logic [GAP_W-1:0]   gap_nxt;
  logic [2:0]         clr_cnt_r;
  logic [2:0]         clr_cnt_nxt;
  cbt_tx_req_t        req_r;
  cbt_tx_req_t        req_nxt;
  logic [DATA_W-1:0]  rdata_r;
  logic [DATA_W-1:0]  rdata_nxt;
  logic               match_r;
  logic               match_nxt;
  logic [DATA_W-1:0]  mask_mem_r [MASK_HALVES];
  logic [DATA_W-1:0]  mask_mem_nxt [MASK_HALVES];
  logic [DATA_W-1:0]  mask_wdata;
  logic               mask_hit;
  logic [2:0]         mask_idx;
  logic               wr_ctrl;
  logic               wr_delay;
  logic [3:0]         code_eff;
  logic [GAP_W-1:0]   gap_load;
  logic [ID_W-1:0]    sel_mask;
  logic               id_ok;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // the mask page spans 040h..04Fh, word index from address bits 3..1
  assign mask_hit = (I_BUS.addr[7:4] == MASK_PAGE) && !I_BUS.addr[0];
  assign mask_idx = I_BUS.addr[3:1];
  assign wr_ctrl  = I_BUS.wr && (I_BUS.addr == OFF_CTRL);
  assign wr_delay = I_BUS.wr && (I_BUS.addr == OFF_DELAY);

  // high halves keep identifier bits 28..16 only, top bits stay zero
  assign mask_wdata = mask_idx[0] ? (I_BUS.wdata & MASK_HI_VALID)
                                  : I_BUS.wdata;

  // ----------------------------------------------------------------
  // mask storage
  // ----------------------------------------------------------------
  // only the addressed half takes the write, the others hold
  always_comb begin
    mask_mem_nxt = mask_mem_r;
    if (I_BUS.wr && mask_hit) begin
      mask_mem_nxt[mask_idx] = mask_wdata;
    end
  end

  // no reset on purpose: masks are data and read undefined until
  // software writes them, which also saves reset fanout
  always_ff @(posedge I_MCLK) begin
    mask_mem_r <= mask_mem_nxt;
  end

  // ----------------------------------------------------------------
  // gap length from the delay code
  // ----------------------------------------------------------------
  // prohibited codes above eight saturate so the counter cannot wrap
  // a 13-bit counter holds the longest gap of 2^12 ticks exactly
  always_comb begin
    code_eff = (delay_r > DELAY_MAX) ? DELAY_MAX : delay_r;
    gap_load = GAP_W'(1) << (code_eff + DELAY_EXP_ADD);
  end

  // ----------------------------------------------------------------
  // control register, delay register and engine next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt   = state_r;
    run_nxt     = run_r;
    delay_nxt   = delay_r;
    idx_nxt     = idx_r;
    gap_nxt     = gap_r;
    clr_cnt_nxt = clr_cnt_r;
    req_nxt     = req_r;

    if (wr_delay) begin
      delay_nxt = I_BUS.wdata[DELAY_W-1:0];
    end

    // set/clear pair, equal bits leave the flag alone
    if (wr_ctrl) begin
      if (I_BUS.wdata[WR_START_BIT] && !I_BUS.wdata[WR_STOP_BIT]) begin
        run_nxt = 1'b1;
      end else if (!I_BUS.wdata[WR_START_BIT] &&
                   I_BUS.wdata[WR_STOP_BIT]) begin
        run_nxt = 1'b0;
      end
    end

    unique case (state_r)
      ST_IDLE: begin
        req_nxt.valid = 1'b0;
        if (run_r) begin
          state_nxt = ST_REQ;
        end
      end
      ST_REQ: begin
        // hold off while ordinary buffers want the bus
        // this only postpones the frame, so the delay is a minimum
        req_nxt.valid   = run_r && !I_ORD_PEND;
        req_nxt.buf_idx = idx_r;
        if (!run_r) begin
          state_nxt     = ST_IDLE;
          req_nxt.valid = 1'b0;
        end else if (req_r.valid && I_TX_ACK) begin
          state_nxt     = ST_BUSY;
          req_nxt.valid = 1'b0;
        end
      end
      ST_BUSY: begin
        req_nxt.valid = 1'b0;
        // a frame on the wire runs to its end unless a clear is written
        // the index moves on even when stopped, so a restart keeps order
        if (I_TX_DONE) begin
          idx_nxt = idx_r + 3'h1;
          if (delay_r == DELAY_RESET) begin
            state_nxt = run_r ? ST_REQ : ST_IDLE;
          end else begin
            state_nxt = ST_GAP;
            gap_nxt   = gap_load;
          end
        end
      end
      ST_GAP: begin
        // a stop ends the gap at once, no frame is owed after it
        req_nxt.valid = 1'b0;
        if (!run_r) begin
          state_nxt = ST_IDLE;
        end else if (I_DBT_TICK) begin
          gap_nxt = gap_r - GAP_W'(1);
          if (gap_r == GAP_W'(1)) begin
            state_nxt = ST_REQ;
          end
        end
      end
      ST_CLEAR: begin
        req_nxt.valid = 1'b0;
        // index back to buffer zero so the next start begins there
        idx_nxt       = BUF_FIRST;
        gap_nxt       = '0;
        clr_cnt_nxt   = clr_cnt_r - 3'h1;
        // the status bit stays up for a fixed count, then drops itself
        if (clr_cnt_r == 3'h1) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase

    // clear request overrides whatever the engine was doing
    // software stops first; a clear while running may cut a request
    if (wr_ctrl && I_BUS.wdata[WR_CLR_BIT]) begin
      state_nxt     = ST_CLEAR;
      clr_cnt_nxt   = CLEAR_CYCLES;
      req_nxt.valid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control and engine registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      state_r   <= ST_IDLE;
      run_r     <= CTRL_RESET[RD_RUN_BIT];
      delay_r   <= DELAY_RESET;
      idx_r     <= BUF_FIRST;
      gap_r     <= '0;
      clr_cnt_r <= '0;
      req_r     <= '0;
    end else begin
      state_r   <= state_nxt;
      run_r     <= run_nxt;
      delay_r   <= delay_nxt;
      idx_r     <= idx_nxt;
      gap_r     <= gap_nxt;
      clr_cnt_r <= clr_cnt_nxt;
      req_r     <= req_nxt;
    end
  end

  // ----------------------------------------------------------------
  // identifier acceptance
  // ----------------------------------------------------------------
  // select 0 compares every bit, 1..4 pick a mask pair
  // a pair never written compares undefined, so software must load
  // it before pointing a buffer at it
  always_comb begin
    sel_mask = '0;
    if (I_MASK_SEL >= 3'h1 && I_MASK_SEL <= 3'h4) begin
      sel_mask = {mask_mem_r[{I_MASK_SEL[1:0] - 2'h1, 1'b1}][12:0],
                  mask_mem_r[{I_MASK_SEL[1:0] - 2'h1, 1'b0}]};
    end
  end

  cbt_id_match u_match (
    .i_rx_id  (I_RX_ID),
    .i_buf_id (I_BUF_ID),
    .i_mask   (sel_mask),
    .o_match  (id_ok)
  );

  // ----------------------------------------------------------------
  // read data, one cycle after the read strobe
  // ----------------------------------------------------------------
  // unmapped addresses and idle cycles read as zero
  // the control word shows only its two status bits, the rest zero
  always_comb begin
    rdata_nxt = '0;
    match_nxt = id_ok;
    if (I_BUS.rd) begin
      if (I_BUS.addr == OFF_CTRL) begin
        rdata_nxt[RD_RUN_BIT] = run_r;
        rdata_nxt[RD_CLR_BIT] = (state_r == ST_CLEAR);
      end else if (I_BUS.addr == OFF_DELAY) begin
        rdata_nxt[DELAY_W-1:0] = delay_r;
      end else if (mask_hit) begin
        rdata_nxt = mask_mem_r[mask_idx];
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      rdata_r <= '0;
      match_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      match_r <= match_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // run and clear status mirror their next values, so the pins
  // agree with what a read in the same cycle returns
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      O_RUN      <= 1'b0;
      O_CLEARING <= 1'b0;
    end else begin
      O_RUN      <= run_nxt;
      O_CLEARING <= (state_nxt == ST_CLEAR);
    end
  end

  assign O_RDATA    = rdata_r;
  assign O_TX_REQ   = req_r;
  assign O_ID_MATCH = match_r;

endmodule

// ===== testbench/cbt_node_model.sv
// partner bit engine standing in for the other nodes on the bus
// assumes the block's request carrier and one shared clock
`timescale 1ns/1ns

module cbt_node_model (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire cbt_pkg::cbt_tx_req_t i_req,
  input  wire logic                 i_slow,
  output logic                      o_ack,
  output logic                      o_done,
  output logic                      o_tick
);
  import cbt_pkg::*;
  // ----------------------------------------------------------------
  // acknowledge, frame length and bit time pulses
  // ----------------------------------------------------------------
  logic [3:0] cnt_r;
  logic [2:0] wt_r;
  logic       busy_r;

  // slow mode stands for lost arbitration: the ack comes late
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      {o_ack, o_done, o_tick, busy_r, cnt_r, wt_r} <= '0;
    end else begin
      o_tick <= ~o_tick;
      o_ack  <= 1'b0;
      o_done <= 1'b0;
      if (busy_r) begin
        cnt_r  <= cnt_r - 4'h1;
        busy_r <= (cnt_r != 4'h1);
        o_done <= (cnt_r == 4'h1);
      end else if (i_req.valid && !o_ack) begin
        wt_r <= wt_r + 3'h1;
        if (wt_r >= {1'b0, i_slow, i_slow}) begin
          o_ack  <= 1'b1;
          busy_r <= 1'b1;
          cnt_r  <= 4'hA;
          wt_r   <= 3'h0;
        end
      end
    end
  end
endmodule

// ===== testbench/cbt_monitor.sv
// checker of the block-transmit control ports
// assumes it is bound into the top module and sees only its ports
`timescale 1ns/1ns

module cbt_monitor (
  input  wire logic                      I_MCLK,
  input  wire logic                      I_RESET_N,
  input  wire cbt_pkg::cbt_bus_req_t     I_BUS,
  input  wire logic                      I_ORD_PEND,
  input  wire logic                      I_TX_ACK,
  input  wire logic [cbt_pkg::DATA_W-1:0] O_RDATA,
  input  wire cbt_pkg::cbt_tx_req_t      O_TX_REQ,
  input  wire logic                      O_RUN,
  input  wire logic                      O_CLEARING
);
  import cbt_pkg::*;
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic       ctl_w;
  logic       acked_r;
  logic       clr_r;
  logic [2:0] last_r;
  assign ctl_w = I_BUS.wr && (I_BUS.addr == OFF_CTRL);

  // last acked buffer; a clear forgets it since the index restarts
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      acked_r <= 1'b0;
      clr_r   <= 1'b0;
      last_r  <= 3'h0;
    end else begin
      clr_r <= O_CLEARING || (clr_r && !O_TX_REQ.valid);
      if (O_TX_REQ.valid && I_TX_ACK) begin
        acked_r <= 1'b1;
        last_r  <= O_TX_REQ.buf_idx;
      end else if (O_CLEARING || $rose(O_TX_REQ.valid)) begin
        acked_r <= 1'b0;
      end
    end
  end

  sequence s_clr_run;
    O_CLEARING [*4] ##1 !O_CLEARING;
  endsequence
  property p_clear;
    ctl_w && I_BUS.wdata[WR_CLR_BIT] |=> s_clr_run;
  endproperty
  property p_start;
    ctl_w && I_BUS.wdata[WR_START_BIT] && !I_BUS.wdata[WR_STOP_BIT]
      |=> O_RUN;
  endproperty
  property p_stop;
    ctl_w && !I_BUS.wdata[WR_START_BIT] && I_BUS.wdata[WR_STOP_BIT]
      |=> !O_RUN;
  endproperty
  property p_keep;
    !(ctl_w && (I_BUS.wdata[WR_START_BIT] ^ I_BUS.wdata[WR_STOP_BIT]))
      |=> $stable(O_RUN);
  endproperty
  property p_clr_idx;
    O_TX_REQ.valid && clr_r |-> O_TX_REQ.buf_idx == BUF_FIRST;
  endproperty
  property p_step;
    $rose(O_TX_REQ.valid) && acked_r |-> O_TX_REQ.buf_idx == last_r + 3'h1;
  endproperty
  property p_ack;
    O_TX_REQ.valid && I_TX_ACK |=> !O_TX_REQ.valid;
  endproperty
  property p_pend;
    $rose(O_TX_REQ.valid) |-> !$past(I_ORD_PEND);
  endproperty
  property p_rd_delay;
    I_BUS.rd && I_BUS.addr == OFF_DELAY |=> O_RDATA[15:4] == 12'h000;
  endproperty
  property p_rd_hi;
    I_BUS.rd && (I_BUS.addr == OFF_MASK1_HI || I_BUS.addr == OFF_MASK2_HI)
      |=> O_RDATA[15:13] == 3'h0;
  endproperty

  a_clear: assert property (p_clear)
    else $error("clear status length wrong");
  a_start: assert property (p_start)
    else $error("run flag not set");
  a_stop: assert property (p_stop)
    else $error("run flag not cleared");
  a_keep: assert property (p_keep)
    else $error("run flag moved");
  a_clr_idx: assert property (p_clr_idx)
    else $error("no restart at buffer zero");
  a_step: assert property (p_step)
    else $error("buffer order broken");
  a_ack: assert property (p_ack)
    else $error("request kept after ack");
  a_pend: assert property (p_pend)
    else $error("request while held off");
  a_rd_delay: assert property (p_rd_delay)
    else $error("delay upper bits set");
  a_rd_hi: assert property (p_rd_hi)
    else $error("mask high bits set");
endmodule

bind cbt_top cbt_monitor mon_u (
  .I_MCLK, .I_RESET_N, .I_BUS, .I_ORD_PEND, .I_TX_ACK,
  .O_RDATA, .O_TX_REQ, .O_RUN, .O_CLEARING
);

// ===== testbench/tb_top.sv
// testbench of the block-transmit control and identifier masks
// assumes the partner bit engine model and the bound checker
`timescale 1ns/1ns

module tb_top;
  import cbt_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n;
  cbt_bus_req_t      bus;
  logic              tick, pend, ack, done, slow, match, run, clring;
  logic [ID_W-1:0]   rx;
  logic [ID_W-1:0]   bid;
  logic [2:0]        sel;
  logic [DATA_W-1:0] rdata;
  cbt_tx_req_t       req;
  int                n_fail = 0;
  int                num_checks = 0;
  int                ncyc;

  always #10 clk = ~clk;

  cbt_top dut_u (
    .I_MCLK(clk), .I_RESET_N(rst_n), .I_BUS(bus), .I_DBT_TICK(tick),
    .I_ORD_PEND(pend), .I_TX_ACK(ack), .I_TX_DONE(done), .I_RX_ID(rx),
    .I_BUF_ID(bid), .I_MASK_SEL(sel), .O_RDATA(rdata), .O_TX_REQ(req),
    .O_RUN(run), .O_CLEARING(clring), .O_ID_MATCH(match)
  );
  cbt_node_model node_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_slow(slow),
    .o_ack(ack), .o_done(done), .o_tick(tick)
  );

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input string nm);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, e, nm);
  endtask
  task automatic idm(input logic [ID_W-1:0] id, input logic [2:0] s,
                     input logic e);
    @(posedge clk);
    rx  <= id;
    sel <= s;
    @(posedge clk);
    #1 chk({15'h0, match}, {15'h0, e}, "id match");
  endtask
  // bounded wait; ncyc tells how long the request level took
  task automatic wait_req(input logic lvl);
    ncyc = 0;
    while (req.valid !== lvl) begin
      @(posedge clk);
      #1 ncyc++;
      if (ncyc > 5000) begin
        n_fail++;
        $display("mismatch request wait expected %b seen timeout", lvl);
        complete_run();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    bus = '0;
    rst_n = 1'b0;
    pend = 1'b0;
    slow = 1'b0;
    rx = '0;
    bid = '0;
    sel = 3'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFF_CTRL, CTRL_RESET, "ctrl");
    rd(OFF_DELAY, 16'h0000, "delay");
    wr(OFF_DELAY, 16'h00F3);
    rd(OFF_DELAY, 16'h0003, "delay");
    rd(8'h09, 16'h0000, "unmapped");
    wr(OFF_DELAY, 16'h0000);
    wr(OFF_MASK1_HI, 16'hFFFF);
    rd(OFF_MASK1_HI, MASK_HI_VALID, "mask1 hi");
    wr(OFF_MASK2_HI, 16'hFFFF);
    rd(OFF_MASK2_HI, MASK_HI_VALID, "mask2 hi");
    wr(OFF_MASK1_LO, 16'h000F);
    rd(OFF_MASK1_LO, 16'h000F, "mask1 lo");
    wr(OFF_MASK2_LO, 16'hA5C3);
    rd(OFF_MASK2_LO, 16'hA5C3, "mask2 lo");
    wr(OFF_MASK1_HI, 16'h0000);
    idm(29'h00000001, 3'h1, 1'b1);
    idm(29'h00000010, 3'h1, 1'b0);
    idm(29'h10000000, 3'h1, 1'b0);
    idm(29'h10000000, 3'h2, 1'b1);
    idm(29'h00000004, 3'h2, 1'b0);
    idm(29'h00000001, 3'h0, 1'b0);
    wr(8'h4C, 16'hFFFF);
    wr(8'h4E, 16'hFFFF);
    bid <= 29'h15555555;
    rd(8'h4E, MASK_HI_VALID, "mask4 hi");
    idm(29'h0AAAAAAA, 3'h4, 1'b1);
    idm(29'h15555555, 3'h0, 1'b1);
    idm(29'h15555554, 3'h7, 1'b0);
    // start and stop together must leave the flag alone
    wr(OFF_CTRL, 16'h0101);
    rd(OFF_CTRL, 16'h0000, "run hold");
    wr(OFF_CTRL, 16'h0100);
    #1 chk({15'h0, run}, 16'h0001, "run pin");
    for (int i = 0; i < 9; i++) begin
      wait_req(1'b1);
      chk({13'h0, req.buf_idx}, 16'(i % 8), "buffer");
      wait_req(1'b0);
    end
    wr(OFF_CTRL, 16'h0001);
    #1 chk({15'h0, run}, 16'h0000, "run pin");
    rd(OFF_CTRL, 16'h0000, "run stop");
    repeat (20) @(posedge clk);
    // clear only once the flag reads zero
    wr(OFF_CTRL, 16'h0200);
    rd(OFF_CTRL, 16'h0002, "clearing");
    repeat (6) @(posedge clk);
    #1 chk({15'h0, clring}, 16'h0000, "clear end");
    @(posedge clk);
    slow <= 1'b1;
    pend <= 1'b1;
    wr(OFF_CTRL, 16'h0100);
    repeat (8) @(posedge clk);
    #1 chk({15'h0, req.valid}, 16'h0000, "held off");
    @(posedge clk);
    pend <= 1'b0;
    wait_req(1'b1);
    chk({13'h0, req.buf_idx}, 16'h0000, "restart");
    wait_req(1'b0);
    // delay only changes while stopped; one tick every two cycles
    wr(OFF_CTRL, 16'h0001);
    repeat (40) @(posedge clk);
    wr(OFF_DELAY, 16'h0001);
    slow <= 1'b0;
    wr(OFF_CTRL, 16'h0100);
    wait_req(1'b1);
    wait_req(1'b0);
    wait_req(1'b1);
    chk(16'(ncyc >= 72 && ncyc <= 90), 16'h0001, "gap");
    wr(OFF_CTRL, 16'h0001);
    wr(OFF_CTRL, 16'h0000);
    rd(OFF_CTRL, 16'h0000, "ctrl zero");
    complete_run();
  end
endmodule
